// >>> rtl/snf_front_end.v
// Serial NAND command front end with feature and status registers
//
// Operation
// - Hold honoured only when quad enable clear
// - Hold pauses link, array operation continues
// - Hold starts on hold fall, clock low
// - Hold ends on hold rise, clock low
// - During hold output floats, inputs ignored
// - Chip select high during hold resets interface
// - Protect lock with pin low freezes bits
// - Opcode 06 sets latch; needed for program and erase
// - Opcode 04 or write completion clears latch
// - Reset command clears write latch
// - 0F reads, 1F writes feature register
// - Status register read only
// - Feature settings survive reset command
// - Quad commands need quad enable set
// - Set feature accepts optional dummy byte
// - Configuration volatile, one-time lock held only until reset
// - Get feature refreshes byte until deselect
// - Reset while busy aborts operation
// - Reset while idle clears fail, ECC bits
// - Random loads only inside data move
// - Sample on rising, shift on falling edge
`timescale 1ns/1ns
`include "snf_defines.vh"
module snf_front_end (
  // Clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // Serial link pins
  input wire cs_n_i,
  input wire sclk_i,
  input wire sio0_i,
  input wire wp_n_i,
  input wire hold_n_i,
  output reg so_o,
  output reg so_oe_o,
  // Array core status
  input wire prog_fail_i,
  input wire erase_fail_i,
  input wire [2:0] ecc_result_i,
  input wire ecc_result_vld_i,
  // Array operation strobes
  output reg op_start_o,
  output reg [7:0] op_code_o,
  output reg op_abort_o,
  output reg busy_o,
  output reg quad_en_o,
  output reg quad_cmd_ok_o
);
  // Link state machine codes
  localparam ST_OPC = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_DATA = 3'd2;
  localparam ST_GETOUT = 3'd3;
  localparam ST_ARG = 3'd4;
  localparam ST_IGNORE = 3'd5;

  localparam integer BUSY_CYC_I = `SNF_BUSY_CYC;
  localparam [7:0] BUSY_CYC = BUSY_CYC_I[7:0];

  // Synchronised pins
  wire cs_n_s;
  wire sclk_s;
  wire sio0_s;
  wire wp_n_s;
  wire hold_n_s;

  snf_sync2 u_cs (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .async_i(cs_n_i), .sync_o(cs_n_s));
  snf_sync2 u_sclk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .async_i(sclk_i), .sync_o(sclk_s));
  snf_sync2 u_sio0 (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .async_i(sio0_i), .sync_o(sio0_s));
  snf_sync2 u_wp (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .async_i(wp_n_i), .sync_o(wp_n_s));
  snf_sync2 u_hold (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .async_i(hold_n_i), .sync_o(hold_n_s));

  reg sclk_d_r;
  reg hold_d_r;
  reg hold_act_r;
  reg hold_entry_r;
  reg hold_exit_r;
  reg [2:0] state_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] opcode_r;
  reg [7:0] faddr_r;
  reg [7:0] out_r;
  reg [7:0] arg_cnt_r;
  reg [7:0] prot_r;
  reg [7:0] cfg_r;
  reg [7:0] drv_r;
  reg wel_r;
  reg pfail_r;
  reg efail_r;
  reg [2:0] ecc_r;
  reg [7:0] busy_cnt_r;
  reg move_ok_r;

  // Feature register read mux, reserved bits zero
  function [7:0] feat_read;
    input [7:0] a;
    input [7:0] p;
    input [7:0] c;
    input [7:0] st;
    input [7:0] d;
    begin
      case (a)
        `SNF_ADDR_PROT: feat_read = p & `SNF_PROT_MASK;
        `SNF_ADDR_CFG: feat_read = c & `SNF_CFG_MASK;
        `SNF_ADDR_STAT: feat_read = st;
        `SNF_ADDR_DRV: feat_read = d & `SNF_DRV_MASK;
        default: feat_read = 8'h00;
      endcase
    end
  endfunction

  // Array commands that need the latch and clear it when done
  function needs_wel;
    input [7:0] op;
    begin
      needs_wel = (op == `SNF_OP_PROG_EXEC) ||
        (op == `SNF_OP_BLOCK_ERASE);
    end
  endfunction

  wire [7:0] status_w = {1'b0, ecc_r, pfail_r, efail_r, wel_r, busy_o};
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire hold_en = ~cfg_r[`SNF_CFG_QE_BIT];
  wire link_run = ~cs_n_s & ~hold_act_r;
  wire [7:0] byte_in = {shift_r[6:0], sio0_s};
  wire byte_done = link_run & sclk_rise & (bit_cnt_r == 3'd7);
  wire prot_locked = prot_r[`SNF_PROT_WD_BIT] & ~wp_n_s;

  // Hold entry and exit, deferred while the clock is high
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sclk_d_r <= 1'b0;
      hold_d_r <= 1'b1;
      hold_act_r <= 1'b0;
      hold_entry_r <= 1'b0;
      hold_exit_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      hold_d_r <= hold_n_s;
      if (cs_n_s || !hold_en) begin
        // Deselect drops hold so a new frame starts clean
        hold_act_r <= 1'b0;
        hold_entry_r <= 1'b0;
        hold_exit_r <= 1'b0;
      end else begin
        if (hold_d_r && !hold_n_s)
          hold_entry_r <= 1'b1;
        if (!hold_d_r && hold_n_s)
          hold_exit_r <= 1'b1;
        if (hold_entry_r && !sclk_s) begin
          hold_act_r <= 1'b1;
          hold_entry_r <= 1'b0;
        end
        if (hold_exit_r && !sclk_s && !hold_entry_r) begin
          hold_act_r <= 1'b0;
          hold_exit_r <= 1'b0;
        end
      end
    end
  end

  // Command decode, feature access, write latch and busy timer
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_r <= ST_OPC;
      bit_cnt_r <= 3'd0;
      shift_r <= 8'h00;
      opcode_r <= 8'h00;
      faddr_r <= 8'h00;
      out_r <= 8'h00;
      arg_cnt_r <= 8'h00;
      prot_r <= `SNF_PROT_RST;
      cfg_r <= `SNF_CFG_RST;
      drv_r <= `SNF_DRV_RST;
      wel_r <= 1'b0;
      pfail_r <= 1'b0;
      efail_r <= 1'b0;
      ecc_r <= 3'd0;
      busy_cnt_r <= 8'h00;
      busy_o <= 1'b0;
      move_ok_r <= 1'b0;
      op_start_o <= 1'b0;
      op_code_o <= 8'h00;
      op_abort_o <= 1'b0;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      quad_en_o <= 1'b0;
      quad_cmd_ok_o <= 1'b0;
    end else begin
      op_start_o <= 1'b0;
      op_abort_o <= 1'b0;
      quad_en_o <= cfg_r[`SNF_CFG_QE_BIT];
      if (busy_o) begin
        if (busy_cnt_r == 8'h01) begin
          busy_o <= 1'b0;
          if (needs_wel(op_code_o))
            wel_r <= 1'b0;
        end
        busy_cnt_r <= busy_cnt_r - 8'h01;
      end
      if (cs_n_s) begin
        // Deselect ends any frame and resets the link logic
        state_r <= ST_OPC;
        bit_cnt_r <= 3'd0;
        so_oe_o <= 1'b0;
        quad_cmd_ok_o <= 1'b0;
      end else if (hold_act_r) begin
        so_oe_o <= 1'b0;
      end else begin
        if (state_r == ST_GETOUT) begin
          so_oe_o <= 1'b1;
          if (sclk_fall) begin
            // Shift on falling edge, reload live value each byte
            so_o <= out_r[7];
            if (bit_cnt_r == 3'd7)
              out_r <= feat_read(faddr_r, prot_r, cfg_r, status_w,
                drv_r);
            else
              out_r <= {out_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 3'd1;
          end
        end else if (sclk_rise) begin
          shift_r <= byte_in;
          bit_cnt_r <= bit_cnt_r + 3'd1;
        end
        if (byte_done && state_r != ST_GETOUT) begin
          case (state_r)
            ST_OPC: begin
              opcode_r <= byte_in;
              state_r <= ST_IGNORE;
              case (byte_in)
                `SNF_OP_SET_WRITE_LATCH_CMD_SET: wel_r <= 1'b1;
                `SNF_OP_SET_WRITE_LATCH_CMD_CLR: wel_r <= 1'b0;
                `SNF_OP_GET_FEAT: state_r <= ST_ADDR;
                `SNF_OP_SET_FEAT: state_r <= ST_ADDR;
                `SNF_OP_RESET: begin
                  wel_r <= 1'b0;
                  move_ok_r <= 1'b0;
                  if (busy_o) begin
                    busy_o <= 1'b0;
                    busy_cnt_r <= 8'h00;
                    op_abort_o <= 1'b1;
                  end else begin
                    pfail_r <= 1'b0;
                    efail_r <= 1'b0;
                    ecc_r <= 3'd0;
                  end
                end
                `SNF_OP_RD_CACHE_X4, `SNF_OP_RD_CACHE_QIO,
                `SNF_OP_PROG_LOAD_X4:
                  quad_cmd_ok_o <= cfg_r[`SNF_CFG_QE_BIT];
                `SNF_OP_RAND_LOAD:
                  quad_cmd_ok_o <= 1'b0;
                `SNF_OP_RAND_LOAD_X4A, `SNF_OP_RAND_LOAD_X4B:
                  quad_cmd_ok_o <= cfg_r[`SNF_CFG_QE_BIT] &
                    move_ok_r;
                `SNF_OP_PAGE_READ, `SNF_OP_PROG_EXEC,
                `SNF_OP_BLOCK_ERASE: begin
                  state_r <= ST_ARG;
                  arg_cnt_r <= 8'h00;
                end
                default: state_r <= ST_IGNORE;
              endcase
            end
            ST_ARG: begin
              // Three address bytes then launch
              arg_cnt_r <= arg_cnt_r + 8'h01;
              if (arg_cnt_r == 8'h02) begin
                state_r <= ST_IGNORE;
                if (!busy_o && (!needs_wel(opcode_r) || wel_r)) begin
                  op_start_o <= 1'b1;
                  op_code_o <= opcode_r;
                  busy_o <= 1'b1;
                  busy_cnt_r <= BUSY_CYC;
                  // Data move window opens after a page read
                  move_ok_r <= (opcode_r == `SNF_OP_PAGE_READ);
                end
              end
            end
            ST_ADDR: begin
              faddr_r <= byte_in;
              if (opcode_r == `SNF_OP_GET_FEAT) begin
                state_r <= ST_GETOUT;
                out_r <= feat_read(byte_in, prot_r, cfg_r, status_w,
                  drv_r);
              end else begin
                state_r <= ST_DATA;
              end
            end
            ST_DATA: begin
              // Trailing optional dummy byte is ignored
              state_r <= ST_IGNORE;
              case (faddr_r)
                `SNF_ADDR_PROT: begin
                  if (prot_locked)
                    prot_r <= (prot_r & `SNF_PROT_LOCK_MASK) |
                      (byte_in & ~`SNF_PROT_LOCK_MASK & `SNF_PROT_MASK);
                  else
                    prot_r <= byte_in & `SNF_PROT_MASK;
                end
                `SNF_ADDR_CFG: begin
                  // One-time lock can only be set by a write; only reset clears it
                  cfg_r <= (byte_in & `SNF_CFG_MASK) |
                    (cfg_r & 8'h80);
                end
                `SNF_ADDR_DRV: drv_r <= byte_in & `SNF_DRV_MASK;
                default: cfg_r <= cfg_r;
              endcase
            end
            default: state_r <= ST_IGNORE;
          endcase
          // Random load outside a data move is dropped
          if (state_r == ST_OPC && byte_in == `SNF_OP_RAND_LOAD &&
              move_ok_r) begin
            op_start_o <= 1'b1;
            op_code_o <= byte_in;
          end
        end
      end
      // Result capture last: a new result beats a same-cycle reset clear
      if (ecc_result_vld_i) begin
        pfail_r <= prog_fail_i;
        efail_r <= erase_fail_i;
        ecc_r <= ecc_result_i;
      end
    end
  end
endmodule

// >>> rtl/snf_defines.vh
// Constants for the serial NAND command front end
`ifndef SNF_DEFINES_VH
`define SNF_DEFINES_VH
// Opcodes
`define SNF_OP_SET_WRITE_LATCH_CMD_SET 8'h06
`define SNF_OP_SET_WRITE_LATCH_CMD_CLR 8'h04
`define SNF_OP_GET_FEAT 8'h0f
`define SNF_OP_SET_FEAT 8'h1f
`define SNF_OP_RESET 8'hff
`define SNF_OP_PAGE_READ 8'h13
`define SNF_OP_PROG_EXEC 8'h10
`define SNF_OP_BLOCK_ERASE 8'hd8
`define SNF_OP_RD_CACHE_X4 8'h6b
`define SNF_OP_RD_CACHE_QIO 8'heb
`define SNF_OP_PROG_LOAD_X4 8'h32
`define SNF_OP_RAND_LOAD 8'h84
`define SNF_OP_RAND_LOAD_X4A 8'hc4
`define SNF_OP_RAND_LOAD_X4B 8'h34
// Feature addresses
`define SNF_ADDR_PROT 8'ha0
`define SNF_ADDR_CFG 8'hb0
`define SNF_ADDR_STAT 8'hc0
`define SNF_ADDR_DRV 8'hd0
// Writable bit masks (reserved bits read zero)
`define SNF_PROT_MASK 8'hbe
`define SNF_PROT_LOCK_MASK 8'h3e
`define SNF_CFG_MASK 8'hd1
`define SNF_DRV_MASK 8'h60
// Field positions
`define SNF_PROT_WD_BIT 7
`define SNF_CFG_OTP_LOCK_BIT 7
`define SNF_CFG_QE_BIT 0
// Reset values
`define SNF_PROT_RST 8'h00
`define SNF_CFG_RST 8'h00
`define SNF_DRV_RST 8'h00
// Busy time of a stand-in array operation, in ns and cycles
`define SNF_BUSY_NS 2000
`define SNF_BUSY_CYC (`SNF_BUSY_NS / 10)
`endif

// >>> rtl/snf_sync2.v
// Two-flop synchroniser for one pin input
`timescale 1ns/1ns
module snf_sync2 (
  // Clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // Async level in, synchronised level out
  input wire async_i,
  output wire sync_o
);
  reg meta_r;
  reg sync_r;

  // First flop feeds only the second
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule

// >>> testbench/snf_front_end_monitor.sv
// Port checker for the serial NAND command front end
`timescale 1ns/1ns
module snf_fe_monitor (
  // Clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // Watched pins and strobes
  input wire cs_n_i,
  input wire sclk_i,
  input wire hold_n_i,
  input wire so_o,
  input wire so_oe_o,
  input wire op_start_o,
  input wire [7:0] op_code_o,
  input wire op_abort_o,
  input wire busy_o,
  input wire quad_en_o,
  input wire quad_cmd_ok_o
);
  reg [8:0] busy_cnt_r;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Busy length, so a hold can be seen not to cut an operation short
  always @(posedge core_clk_i) begin
    if (!resetn_i || !busy_o) busy_cnt_r <= 9'h000;
    else busy_cnt_r <= busy_cnt_r + 9'h001;
  end
  property p_hold_float;
    (!quad_en_o && !cs_n_i && !hold_n_i && !sclk_i)[*6] |-> !so_oe_o;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("output driven in hold");
  property p_qe_no_hold;
    (!cs_n_i)[*4] ##0 (quad_en_o && so_oe_o) |=> so_oe_o;
  endproperty
  a_qe_no_hold: assert property (p_qe_no_hold)
    else $error("output dropped with quad enable set");
  property p_idle_float;
    cs_n_i[*5] |-> !so_oe_o && !quad_cmd_ok_o;
  endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("output active while deselected");
  property p_abort;
    op_abort_o |-> $past(busy_o) ##[0:2] !busy_o;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort without busy or busy kept");
  property p_start;
    op_start_o |-> (busy_o || op_code_o == 8'h84) ##1 !op_start_o;
  endproperty
  a_start: assert property (p_start)
    else $error("launch not followed by busy");
  property p_busy_hold;
    !hold_n_i && busy_o |=> busy_o || busy_cnt_r >= 9'h0c0;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("operation cut short");
  property p_quad;
    quad_cmd_ok_o |-> quad_en_o;
  endproperty
  a_quad: assert property (p_quad)
    else $error("quad command allowed without enable");
  property p_so_edge;
    so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !sclk_i;
  endproperty
  a_so_edge: assert property (p_so_edge)
    else $error("output moved with clock high");
  // Main scenarios reached
  c_abort: cover property (op_abort_o);
  c_read: cover property (so_oe_o ##1 !so_oe_o);
  c_quad: cover property (quad_cmd_ok_o);
endmodule
bind snf_front_end snf_fe_monitor u_mon (.core_clk_i, .resetn_i,
  .cs_n_i, .sclk_i, .hold_n_i, .so_o, .so_oe_o, .op_start_o, .op_code_o,
  .op_abort_o, .busy_o, .quad_en_o, .quad_cmd_ok_o);

// >>> testbench/snf_host_model.sv
// Host controller model driving the serial link pins in mode 0
`timescale 1ns/1ns
module snf_host_model (
  // Link pins
  output reg cs_n_o,
  output reg sclk_o,
  output reg sio0_o,
  output reg hold_n_o,
  input wire so_i
);
  // Deselected, clock parked low between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sio0_o = 1'b0;
    hold_n_o = 1'b1;
  end
  task sel;
    begin
      cs_n_o = 1'b0;
      #62;
    end
  endtask
  // Released data line flips so a stale bit never looks valid
  task desel;
    begin
      cs_n_o = 1'b1;
      sio0_o = ~sio0_o;
      #63;
    end
  endtask
  // One byte each way, MSB first
  task xb(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sio0_o = tx[i];
        #62 sclk_o = 1'b1;
        rx[i] = so_i;
        #63 sclk_o = 1'b0;
      end
    end
  endtask
  // Hold entered with clock low; optional deselect before release
  task hold(input integer n, input drop);
    integer i;
    begin
      hold_n_o = 1'b0;
      #62;
      for (i = 0; i < n; i = i + 1) begin
        sio0_o = ~sio0_o;
        #62 sclk_o = 1'b1;
        #63 sclk_o = 1'b0;
      end
      if (drop) cs_n_o = 1'b1;
      #63;
      hold_n_o = 1'b1;
      #62;
    end
  endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the serial NAND command front end
`timescale 1ns/1ns
`include "snf_defines.vh"
module testbench;
  reg core_clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg wp_n_i = 1'b1;
  reg prog_fail_i = 1'b0;
  reg erase_fail_i = 1'b0;
  reg [2:0] ecc_result_i = 3'h0;
  reg ecc_result_vld_i = 1'b0;
  wire cs_n, sclk, sio0, hold_n, so_o, so_oe_o, op_start_o, op_abort_o;
  wire busy_o, quad_en_o, quad_cmd_ok_o;
  wire [7:0] op_code_o;
  // Released output reads inverted so a stale bit is never taken as data
  wire so_line = so_oe_o ? so_o : ~so_o;
  reg [31:0] seed = 32'h2d5fc0fb;
  reg [7:0] sh [0:3];
  reg [7:0] d, e, ad, v, n0;
  integer err_count = 0, checked = 0, starts = 0, aborts = 0;
  integer i, k, tn = 0;
  always #5 core_clk_i = ~core_clk_i;
  snf_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .sio0_o(sio0),
    .hold_n_o(hold_n), .so_i(so_line));
  snf_front_end dut (.core_clk_i, .resetn_i, .cs_n_i(cs_n),
    .sclk_i(sclk), .sio0_i(sio0), .wp_n_i, .hold_n_i(hold_n), .so_o,
    .so_oe_o, .prog_fail_i, .erase_fail_i, .ecc_result_i,
    .ecc_result_vld_i, .op_start_o, .op_code_o, .op_abort_o, .busy_o,
    .quad_en_o, .quad_cmd_ok_o);
  // Launch and abort pulses counted as they come
  always @(posedge core_clk_i) begin
    if (op_start_o === 1'b1) starts <= starts + 1;
    if (op_abort_o === 1'b1) aborts <= aborts + 1;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Register value after a feature write
  function [7:0] exp_wr(input [7:0] a, input [7:0] o, input [7:0] x,
      input wp);
    case (a)
      8'ha0: exp_wr = (o[7] && !wp) ? (o & 8'h3e) | (x & 8'h80)
          : x & 8'hbe;
      8'hb0: exp_wr = (x & 8'hd1) | (o & 8'h80);
      8'hd0: exp_wr = x & 8'h60;
      default: exp_wr = o;
    endcase
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("%0d checks, %0d mismatches", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task td;
    begin
      tn = tn + 1;
      $display("test %0d done", tn);
    end
  endtask
  task gap;
    repeat (12) @(negedge core_clk_i);
  endtask
  task send(input [31:0] w, input integer nb);
    begin
      host.sel;
      for (k = nb - 1; k >= 0; k = k - 1) host.xb(w[8*k +: 8], d);
      host.desel;
      gap;
    end
  endtask
  task wr(input [7:0] a, input [7:0] x, input integer nb);
    begin
      sh[a[5:4]] = exp_wr(a, sh[a[5:4]], x, wp_n_i);
      send(nb == 4 ? {8'h1f, a, x, 8'h00} : {8'h00, 8'h1f, a, x}, nb);
    end
  endtask
  // Feature read of two bytes; hm[0] holds before the opcode with clock
  // pulses, hm[1] holds between the data bytes
  task rd(input [7:0] a, input [1:0] hm);
    begin
      host.sel;
      if (hm[0]) host.hold(6, 1'b0);
      host.xb(`SNF_OP_GET_FEAT, d);
      host.xb(a, d);
      host.xb(8'h00, d);
      if (hm[1]) host.hold(hm[0] ? 2 : 0, 1'b0);
      host.xb(8'h00, e);
      host.desel;
      gap;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] x);
    begin
      rd(a, 2'b00);
      check(d, x);
      check(e, x);
    end
  endtask
  task wait_idle;
    begin
      for (k = 0; k < 400 && busy_o !== 1'b0; k = k + 1) gap;
      if (k == 400) begin
        err_count = err_count + 1;
        print_verdict;
      end
    end
  endtask
  initial begin
    repeat (5) @(negedge core_clk_i);
    resetn_i = 1'b1;
    gap;
    for (i = 0; i < 4; i = i + 1) begin
      sh[i] = 8'h00;
      ad = 8'ha0 + {i[1:0], 4'h0};
      rdc(ad, 8'h00);
    end
    td;
    // Random feature writes, reserved bits zero, with random pin state
    for (i = 0; i < 12; i = i + 1) begin
      seed = lfsr(lfsr(seed));
      ad = 8'ha0 + {seed[1:0], 4'h0};
      v = seed[15:8] & (ad == 8'ha0 ? 8'hbe : ad == 8'hb0 ? 8'h50
          : ad == 8'hd0 ? 8'h60 : 8'hff);
      wp_n_i = seed[16];
      wr(ad, v, seed[17] ? 4 : 3);
      rdc(ad, sh[ad[5:4]]);
    end
    wp_n_i = 1'b1;
    wr(8'ha0, 8'hbe, 3);
    wp_n_i = 1'b0;
    wr(8'ha0, 8'h00, 4);
    rdc(8'ha0, sh[2]);
    wp_n_i = 1'b1;
    wr(8'ha0, 8'h00, 3);
    rdc(8'ha0, 8'h00);
    td;
    {prog_fail_i, erase_fail_i, ecc_result_i, ecc_result_vld_i} = 6'h3b;
    @(negedge core_clk_i);
    ecc_result_vld_i = 1'b0;
    sh[0] = 8'h5c;
    wr(8'hc0, 8'h00, 3);
    rdc(8'hc0, 8'h5c);
    wr(8'ha0, 8'h14, 3);
    send(`SNF_OP_RESET, 1);
    rdc(8'hc0, 8'h00);
    rdc(8'ha0, 8'h14);
    td;
    send(`SNF_OP_SET_WRITE_LATCH_CMD_SET, 1);
    rdc(8'hc0, 8'h02);
    send(`SNF_OP_SET_WRITE_LATCH_CMD_CLR, 1);
    rdc(8'hc0, 8'h00);
    send(`SNF_OP_SET_WRITE_LATCH_CMD_SET, 1);
    send(`SNF_OP_RESET, 1);
    rdc(8'hc0, 8'h00);
    td;
    n0 = starts[7:0];
    send({8'h10, 24'h0}, 4);
    check(starts[7:0] - n0, 8'h00);
    send(`SNF_OP_SET_WRITE_LATCH_CMD_SET, 1);
    send({8'h10, 24'h0}, 4);
    check(starts[7:0] - n0, 8'h01);
    check(op_code_o, 8'h10);
    check({7'h0, busy_o}, 8'h01);
    rd(8'hc0, 2'b11);
    check(d, 8'h00);
    check(e, 8'h00);
    wait_idle;
    td;
    send(`SNF_OP_SET_WRITE_LATCH_CMD_SET, 1);
    send({8'hd8, 24'h0}, 4);
    n0 = aborts[7:0];
    send(`SNF_OP_RESET, 1);
    check(aborts[7:0] - n0, 8'h01);
    check({7'h0, busy_o}, 8'h00);
    td;
    n0 = starts[7:0];
    send({8'h03, 24'h000000}, 4);
    send({8'h84, 24'h0}, 4);
    check(starts[7:0] - n0, 8'h00);
    send({8'h13, 24'h0}, 4);
    wait_idle;
    send({8'h84, 24'h0}, 4);
    check(starts[7:0] - n0, 8'h02);
    check(op_code_o, 8'h84);
    wait_idle;
    td;
    // Hold, then deselect inside it; the next frame starts clean
    host.sel;
    host.xb(`SNF_OP_GET_FEAT, d);
    host.hold(3, 1'b1);
    gap;
    rdc(8'ha0, sh[2]);
    for (i = 0; i < 2; i = i + 1) begin
      wr(8'hb0, {7'h0, i[0]}, 3);
      check({7'h0, quad_en_o}, {7'h0, i[0]});
      rd(8'hb0, 2'b10);
      check(d, {7'h0, i[0]});
      check(e, {7'h0, i[0]});
      host.sel;
      host.xb(`SNF_OP_RD_CACHE_X4, d);
      gap;
      check({7'h0, quad_cmd_ok_o}, {7'h0, i[0]});
      host.desel;
      gap;
    end
    wr(8'hb0, 8'h00, 3);
    td;
    print_verdict;
  end
endmodule
